// ### design/lvds_input_check_and_alarms.sv
// converter-side lvds input checker: pattern test, parity, sticky alarms
`timescale 1ns/1ps
`default_nettype none
`include "lvds_check_defs.svh"
// Behaviour
// RULE1 - pattern test forces analog outputs off
// RULE2 - eight writable key words form reference
// RULE3 - frame start from selected strobe/align edge
// RULE4 - source sends keys 0,1,4,5 / 2,3,6,7
// RULE5 - sequence repeats; one start edge suffices
// RULE6 - shared 16-bit error map of mismatches
// RULE7 - any mismatch sets pattern alarm bit 7
// RULE8 - key0 resets 7a7a; bit errors flagged
// RULE9 - writing zeros clears map and alarm
// RULE10 - software runs 100 frames before clearing
// RULE11 - 33-bit parity against odd/even sense
// RULE12 - rising errors alarm A, falling B
// RULE13 - dual parity: ab+strobe, cd+parity line
// RULE14 - four parity alarms per path and edge
// RULE15 - dual parity needs frame align sync
// RULE16 - alarms sticky until software clears them
// RULE17 - zero write pointer raises zero-check alarm
// RULE18 - fifo two, one, equal and summary alarms
// RULE19 - clock stop, summary and pll alarms
// RULE20 - enabled alarms shut converter output off
// RULE21 - per-alarm mask selects alarm pin sources
// RULE22 - software reads, fixes, resyncs, clears
// RULE23 - alarm pin: registered or of unmasked
module lvds_input_check_and_alarms #(
    parameter int FIFO_DEPTH = 8,
    parameter logic [7:0] GONE_CYCLES = 8'(`CLK_GONE_NS / `PCLK_NS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [FIFO_DEPTH-1:0] fifo_wr_ptr,
    input wire logic [FIFO_DEPTH-1:0] fifo_rd_ptr,
    input wire logic sample_clock,
    input wire logic pll_locked,
    input wire logic transmit_enable_pin,
    output logic alarm_pin,
    output logic analog_out_enable,
    lvds_link_if.device link
);
    import lvds_check_pkg::*;

    dev_state_s s, n;
    logic edge_seen, rise, sync_edge, wr, setup, mapped, shutdown, odd, eab, ecd, e32;
    logic [1:0] slot_now;
    logic [15:0] exp_ab, exp_cd, miss;
    logic [13:0] set, keep;

    // one-hot pointers: true when w lies within d positions of r
    function automatic logic near(input logic [FIFO_DEPTH-1:0] w, input logic [FIFO_DEPTH-1:0] r, input int d);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k <= d; k++) begin
            hit = hit | (|(w & ((r << k) | (r >> (FIFO_DEPTH - k)))));
            hit = hit | (|(w & ((r >> k) | (r << (FIFO_DEPTH - k)))));
        end
        return hit;
    endfunction

    // next state
    always_comb begin
        n = s;
        set = '0;
        miss = 16'h0000;
        exp_ab = 16'h0000;
        exp_cd = 16'h0000;
        sync_edge = 1'b0;
        slot_now = s.slot;
        eab = 1'b0;
        ecd = 1'b0;
        e32 = 1'b0;
        odd = s.ctrl[`CTL_ODD];
        // two-flop synchronisers for everything from outside pclk except the fifo pointers, which are used unsynchronised
        n.clk_s1 = link.data_clock;
        n.clk_s2 = s.clk_s1;
        n.clk_s3 = s.clk_s2;
        n.ab_s1 = link.lane_ab_bus;
        n.ab_s2 = s.ab_s1;
        n.cd_s1 = link.lane_cd_bus;
        n.cd_s2 = s.cd_s1;
        n.strb_s1 = link.input_strobe;
        n.strb_s2 = s.strb_s1;
        n.fa_s1 = link.frame_align;
        n.fa_s2 = s.fa_s1;
        n.par_s1 = link.parity_line;
        n.par_s2 = s.par_s1;
        n.sclk_s1 = sample_clock;
        n.sclk_s2 = s.sclk_s1;
        n.sclk_s3 = s.sclk_s2;
        n.pll_s1 = pll_locked;
        n.pll_s2 = s.pll_s1;
        n.txen_s1 = transmit_enable_pin;
        n.txen_s2 = s.txen_s1;
        edge_seen = s.clk_s2 ^ s.clk_s3;
        rise = s.clk_s2 & ~s.clk_s3;
        // data words are taken on both data clock edges
        if (edge_seen) begin
            // strobe carries parity in dual mode, so it cannot mark frames there
            sync_edge = (s.ctrl[`CTL_SYNC_STRB] && !(s.ctrl[`CTL_PAR_EN] && s.ctrl[`CTL_DUAL])
                && s.strb_s2 && !s.prev_strb)
                || (s.ctrl[`CTL_SYNC_FA] && s.fa_s2 && !s.prev_fa); // see RULE3 see RULE15
            n.prev_strb = s.strb_s2;
            n.prev_fa = s.fa_s2;
            slot_now = sync_edge ? 2'h0 : s.slot + 2'h1; // see RULE5
            exp_ab = s.key[{slot_now[1], 1'b0, slot_now[0]}]; // see RULE4
            exp_cd = s.key[{slot_now[1], 1'b1, slot_now[0]}];
            if (s.ctrl[`CTL_TEST] && (s.synced || sync_edge)) begin
                n.synced = 1'b1;
                n.slot = slot_now;
                miss = (s.ab_s2 ^ exp_ab) | (s.cd_s2 ^ exp_cd); // see RULE2 see RULE6 see RULE8
                set[`AL_PATTERN] = |miss; // see RULE7
            end
            if (s.ctrl[`CTL_PAR_EN] && s.ctrl[`CTL_DUAL]) begin
                eab = (^{s.ab_s2, s.strb_s2}) != odd; // see RULE13
                ecd = (^{s.cd_s2, s.par_s2}) != odd;
                set[`AL_PAR_A] = eab && rise; // see RULE14
                set[`AL_PAR_B] = eab && !rise;
                set[`AL_PAR_C] = ecd && rise;
                set[`AL_PAR_D] = ecd && !rise;
            end else if (s.ctrl[`CTL_PAR_EN]) begin
                e32 = (^{s.ab_s2, s.cd_s2, s.par_s2}) != odd; // see RULE11
                set[`AL_PAR_A] = e32 && rise; // see RULE12
                set[`AL_PAR_B] = e32 && !rise;
            end
        end
        if (!s.ctrl[`CTL_TEST]) begin
            n.synced = 1'b0;
        end
        // stop watchdogs, saturating so a dead clock keeps its alarm raised
        n.dwd = edge_seen ? 8'h00 : ((s.dwd == GONE_CYCLES) ? s.dwd : s.dwd + 8'h01);
        n.swd = (s.sclk_s2 ^ s.sclk_s3) ? 8'h00 : ((s.swd == GONE_CYCLES) ? s.swd : s.swd + 8'h01);
        set[`AL_DATACLK] = (s.dwd == GONE_CYCLES); // see RULE19
        set[`AL_DACCLK] = (s.swd == GONE_CYCLES);
        set[`AL_CLOCK] = set[`AL_DATACLK] | set[`AL_DACCLK];
        set[`AL_PLL] = !s.pll_s2;
        // fifo pointer proximity
        set[`AL_ZERO] = (fifo_wr_ptr == '0); // see RULE17
        set[`AL_TWO] = near(fifo_wr_ptr, fifo_rd_ptr, 2); // see RULE18
        set[`AL_ONE] = near(fifo_wr_ptr, fifo_rd_ptr, 1);
        set[`AL_COLL] = |(fifo_wr_ptr & fifo_rd_ptr);
        set[`AL_FIFO] = set[`AL_TWO] | set[`AL_ONE] | set[`AL_COLL];
        // apb slave; write in access phase, read data latched in setup
        setup = psel && !penable;
        wr = psel && penable && pwrite;
        mapped = (paddr == `OFF_TEST_CTRL) || (paddr == `OFF_SHUTOFF) || (paddr == `OFF_STATUS)
            || (paddr == `OFF_MASK) || (paddr == `OFF_ERRMAP) || (paddr[7:5] == `KEY_BASE_HI);
        if (wr && paddr == `OFF_TEST_CTRL) begin
            n.ctrl = pwdata[15:0];
        end
        if (wr && paddr == `OFF_SHUTOFF) begin
            n.shut = pwdata[1:0];
        end
        if (wr && paddr == `OFF_MASK) begin
            n.mask = pwdata[13:0];
        end
        if (wr && paddr[7:5] == `KEY_BASE_HI && paddr[1:0] == 2'h0) begin
            n.key[paddr[4:2]] = pwdata[15:0]; // see RULE2
        end
        // sticky bits: a written zero clears, a new event in that cycle wins
        keep = (wr && paddr == `OFF_STATUS) ? pwdata[13:0] : '1;
        n.status = (s.status & keep) | set; // see RULE16 see RULE9
        n.errmap = (s.errmap & ((wr && paddr == `OFF_ERRMAP) ? pwdata[15:0] : 16'hffff)) | miss; // see RULE9
        if (setup) begin
            n.prdata = 32'h0000_0000;
            case (paddr)
                `OFF_TEST_CTRL: n.prdata = {16'h0000, s.ctrl};
                `OFF_SHUTOFF: n.prdata = {30'h0000_0000, s.shut};
                `OFF_STATUS: n.prdata = {18'h0_0000, s.status};
                `OFF_MASK: n.prdata = {18'h0_0000, s.mask};
                `OFF_ERRMAP: n.prdata = {16'h0000, s.errmap};
                default: begin
                    if (paddr[7:5] == `KEY_BASE_HI) begin
                        n.prdata = {16'h0000, s.key[paddr[4:2]]};
                    end
                end
            endcase
        end
        // outputs
        n.alarm = |(s.status & ~s.mask); // see RULE21 see RULE23
        shutdown = (s.shut[`SHUT_CLOCK] && s.status[`AL_CLOCK])
            || (s.shut[`SHUT_COLL] && s.status[`AL_COLL]); // see RULE20
        n.out_en = s.txen_s2 && s.ctrl[`CTL_SIFTX] && !s.ctrl[`CTL_TEST] && !shutdown; // see RULE1
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.ctrl <= `CTRL_RESET;
            s.mask <= `MASK_RESET;
            s.key <= {{7{`KEYN_RESET}}, `KEY0_RESET}; // see RULE8
        end else begin
            s <= n;
        end
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s.prdata;
    assign alarm_pin = s.alarm;
    assign analog_out_enable = s.out_en;
endmodule
`default_nettype wire

// ### design/lvds_check_defs.svh
// constants shared by the lvds source and the lvds input checker
`ifndef LVDS_CHECK_DEFS_SVH
`define LVDS_CHECK_DEFS_SVH
// apb byte offsets
`define OFF_TEST_CTRL 8'h00
`define OFF_SHUTOFF 8'h04
`define OFF_STATUS 8'h08
`define OFF_MASK 8'h0c
`define OFF_ERRMAP 8'h10
`define OFF_FRAMES 8'h04
`define KEY_BASE_HI 3'h1
// test_and_parity_control fields
`define CTL_TEST 0
`define CTL_PAR_EN 1
`define CTL_DUAL 2
`define CTL_ODD 3
`define CTL_SIFTX 4
`define CTL_INJECT 5
`define CTL_SYNC_STRB 8
`define CTL_SYNC_FA 9
`define CTL_SYNC_LO 8
`define CTL_SYNC_HI 11
// auto_shutoff_control fields
`define SHUT_CLOCK 0
`define SHUT_COLL 1
// alarm_status_register bit positions
`define AL_ZERO 0
`define AL_TWO 1
`define AL_ONE 2
`define AL_COLL 3
`define AL_FIFO 4
`define AL_DACCLK 5
`define AL_DATACLK 6
`define AL_PATTERN 7
`define AL_PAR_A 8
`define AL_PAR_B 9
`define AL_PAR_C 10
`define AL_PAR_D 11
`define AL_CLOCK 12
`define AL_PLL 13
`define AL_W 14
// reset values
`define KEY0_RESET 16'h7a7a
`define KEYN_RESET 16'h0000
`define MASK_RESET 14'h3fff
`define CTRL_RESET 16'h0000
// timing
`define PCLK_NS 100
`define LINK_HALF_NS 400
`define CLK_GONE_NS 3200
`endif

// ### design/lvds_check_pkg.sv
// types for the lvds source and the lvds input checker
package lvds_check_pkg;
    typedef enum logic [1:0] {SRC_IDLE = 2'b01, SRC_RUN = 2'b10} src_state_e;

    typedef logic [7:0][15:0] key_t;

    typedef struct packed {
        logic clk_s1, clk_s2, clk_s3;
        logic [15:0] ab_s1, ab_s2, cd_s1, cd_s2;
        logic strb_s1, strb_s2, fa_s1, fa_s2, par_s1, par_s2;
        logic sclk_s1, sclk_s2, sclk_s3;
        logic pll_s1, pll_s2, txen_s1, txen_s2;
        logic prev_strb, prev_fa, synced;
        logic [1:0] slot;
        logic [15:0] ctrl;
        logic [1:0] shut;
        logic [13:0] status, mask;
        logic [15:0] errmap;
        key_t key;
        logic [7:0] dwd, swd;
        logic [31:0] prdata;
        logic alarm, out_en;
    } dev_state_s;

    typedef struct packed {
        src_state_e state;
        logic [7:0] cnt;
        logic dclk, first;
        logic [1:0] slot;
        logic [15:0] ab, cd;
        logic strb, fa, par;
        logic [15:0] ctrl;
        key_t key;
        logic [15:0] frames;
        logic [31:0] prdata;
    } src_state_s;
endpackage

// ### design/lvds_link_if.sv
// lvds data link between the source and the input checker
`timescale 1ns/1ps
`default_nettype none
interface lvds_link_if;
    logic data_clock;
    logic [15:0] lane_ab_bus;
    logic [15:0] lane_cd_bus;
    logic input_strobe;
    logic frame_align;
    logic parity_line;
    modport source (output data_clock, lane_ab_bus, lane_cd_bus, input_strobe, frame_align, parity_line);
    modport device (input data_clock, lane_ab_bus, lane_cd_bus, input_strobe, frame_align, parity_line);
endinterface
`default_nettype wire

// ### design/lvds_source.sv
// baseband-side source: drives pattern, parity, strobe and data clock
`timescale 1ns/1ps
`default_nettype none
`include "lvds_check_defs.svh"
module lvds_source #(
    parameter logic [7:0] HALF_CYCLES = 8'(`LINK_HALF_NS / `PCLK_NS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lvds_link_if.source link
);
    import lvds_check_pkg::*;

    src_state_s s, n;
    logic wr, setup, mapped;
    logic [1:0] slot;
    logic [15:0] ab, cd;

    // pattern lanes per slot: ab carries keys 0,1,4,5 and cd keys 2,3,6,7
    always_comb begin
        slot = s.slot;
        ab = s.key[{slot[1], 1'b0, slot[0]}]; // see RULE4
        cd = s.key[{slot[1], 1'b1, slot[0]}];
        if (s.ctrl[`CTL_INJECT] && slot == 2'h0) begin
            ab[0] = ~ab[0];
        end
    end

    // next state
    always_comb begin
        n = s;
        setup = psel && !penable;
        wr = psel && penable && pwrite;
        mapped = (paddr == `OFF_TEST_CTRL) || (paddr == `OFF_FRAMES) || (paddr[7:5] == `KEY_BASE_HI);
        if (wr && paddr == `OFF_TEST_CTRL) begin
            n.ctrl = pwdata[15:0];
        end
        if (wr && paddr[7:5] == `KEY_BASE_HI && paddr[1:0] == 2'h0) begin
            n.key[paddr[4:2]] = pwdata[15:0];
        end
        if (setup) begin
            n.prdata = 32'h0000_0000;
            if (paddr == `OFF_TEST_CTRL) begin
                n.prdata = {16'h0000, s.ctrl};
            end else if (paddr == `OFF_FRAMES) begin
                n.prdata = {16'h0000, s.frames};
            end else if (paddr[7:5] == `KEY_BASE_HI) begin
                n.prdata = {16'h0000, s.key[paddr[4:2]]};
            end
        end
        case (s.state)
            SRC_IDLE: begin
                n.dclk = 1'b0;
                n.cnt = 8'h00;
                n.slot = 2'h0;
                n.first = 1'b1;
                n.strb = 1'b0;
                n.fa = 1'b0;
                if (s.ctrl[`CTL_TEST]) begin
                    n.state = SRC_RUN;
                end
            end
            SRC_RUN: begin
                // divider: data moves mid half-period, clock edge at its end
                n.cnt = (s.cnt == HALF_CYCLES - 8'h01) ? 8'h00 : s.cnt + 8'h01;
                if (s.cnt == HALF_CYCLES - 8'h01) begin
                    n.dclk = ~s.dclk;
                end
                if (s.cnt == (HALF_CYCLES >> 1) - 8'h01) begin
                    n.ab = ab;
                    n.cd = cd;
                    n.fa = s.first && slot == 2'h0; // see RULE5
                    n.strb = (slot == 2'h0);
                    n.par = 1'b0;
                    if (s.ctrl[`CTL_PAR_EN] && s.ctrl[`CTL_DUAL]) begin
                        n.strb = (^ab) ^ s.ctrl[`CTL_ODD]; // see RULE13
                        n.par = (^cd) ^ s.ctrl[`CTL_ODD];
                    end else if (s.ctrl[`CTL_PAR_EN]) begin
                        n.par = (^{ab, cd}) ^ s.ctrl[`CTL_ODD]; // see RULE11
                    end
                    if (slot == 2'h3) begin
                        n.first = 1'b0;
                        n.frames = s.frames + 16'h0001;
                    end
                    n.slot = slot + 2'h1; // see RULE5
                end
                // stop only on a falling edge so the clock rests low, never a one-cycle pulse
                if (!s.ctrl[`CTL_TEST] && s.dclk == 1'b1 && s.cnt == HALF_CYCLES - 8'h01) begin
                    n.state = SRC_IDLE;
                end
            end
            default: begin
                n.state = SRC_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.state <= SRC_IDLE;
            s.first <= 1'b1;
            s.key <= {{7{`KEYN_RESET}}, `KEY0_RESET};
        end else begin
            s <= n;
        end
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = s.prdata;
    assign link.data_clock = s.dclk;
    assign link.lane_ab_bus = s.ab;
    assign link.lane_cd_bus = s.cd;
    assign link.input_strobe = s.strb;
    assign link.frame_align = s.fa;
    assign link.parity_line = s.par;
endmodule
`default_nettype wire

// ### tb/lvds_check_properties.sv
// link-level assertions between the lvds source and the input checker
`timescale 1ns/1ps
`default_nettype none
module lvds_check_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic data_clock,
    input wire logic [15:0] lane_ab_bus,
    input wire logic [15:0] lane_cd_bus,
    input wire logic input_strobe,
    input wire logic frame_align,
    input wire logic parity_line
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // half period of four pclk; a stop only ever leaves the clock low
    AST_CLK_HIGH: assert property ($rose(data_clock) |-> data_clock [*4] ##1 !data_clock)
        else $error("data clock high phase is not four cycles");
    AST_CLK_LOW: assert property ($fell(data_clock) |-> !data_clock [*4])
        else $error("data clock low phase is shorter than four cycles");
    // ab, cd, parity and strobe lines held steady one cycle either side of a data clock edge
    AST_AB_HOLD: assert property ($changed(data_clock) |-> $stable(lane_ab_bus) ##1 $stable(lane_ab_bus))
        else $error("ab lane moved at a data clock edge");
    AST_CD_HOLD: assert property ($changed(data_clock) |-> $stable(lane_cd_bus) ##1 $stable(lane_cd_bus))
        else $error("cd lane moved at a data clock edge");
    AST_PAR_HOLD: assert property ($changed(data_clock) |-> $stable(parity_line) ##1 $stable(parity_line))
        else $error("parity line moved at a data clock edge");
    AST_STRB_HOLD: assert property ($changed(data_clock) |-> $stable(input_strobe) ##1 $stable(input_strobe))
        else $error("input strobe moved at a data clock edge");
    // frame start marker leads the first rising edge and lasts one slot
    AST_FA_LEAD: assert property ($rose(frame_align) |-> ##2 $rose(data_clock))
        else $error("frame align not followed by a rising data clock");
    AST_FA_WIDTH: assert property ($rose(frame_align) |-> frame_align [*4] ##1 !frame_align)
        else $error("frame align not exactly one slot wide");
endmodule
`default_nettype wire

// ### tb/lvds_input_check_and_alarms_tb.sv
// self-checking bench: lvds source driving the input checker
`timescale 1ns/1ps
`default_nettype none
`include "lvds_check_defs.svh"
module lvds_input_check_and_alarms_tb;
    logic pclk, presetn, psel_src, psel_dev, penable, pwrite;
    logic [7:0] paddr, wr_ptr, rd_ptr;
    logic [31:0] pwdata, rd_src, rd_dev, q;
    logic rdy_src, rdy_dev, err_src, err_dev, qerr;
    logic sample_clock, sclk_run, pll_locked, txen, alarm_pin, aoe;
    int errors, tests_run;
    lvds_link_if link ();
    lvds_source i_lvds_source (.pclk(pclk), .presetn(presetn), .psel(psel_src), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_src), .pready(rdy_src),
        .pslverr(err_src), .link(link));
    lvds_input_check_and_alarms i_lvds_input_check_and_alarms (.pclk(pclk), .presetn(presetn),
        .psel(psel_dev), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(rd_dev), .pready(rdy_dev), .pslverr(err_dev), .fifo_wr_ptr(wr_ptr), .fifo_rd_ptr(rd_ptr),
        .sample_clock(sample_clock), .pll_locked(pll_locked), .transmit_enable_pin(txen),
        .alarm_pin(alarm_pin), .analog_out_enable(aoe), .link(link));
    lvds_check_properties i_lvds_check_properties (.pclk(pclk), .presetn(presetn),
        .data_clock(link.data_clock), .lane_ab_bus(link.lane_ab_bus), .lane_cd_bus(link.lane_cd_bus),
        .input_strobe(link.input_strobe), .frame_align(link.frame_align), .parity_line(link.parity_line));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // converter sample clock at half pclk, stoppable
    always @(posedge pclk) begin
        if (sclk_run) sample_clock <= ~sample_clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; dev selects the checker, else the source
    task automatic apb(input logic dev, input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel_dev <= dev;
        psel_src <= !dev;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while ((dev ? rdy_dev : rdy_src) !== 1'b1) @(posedge pclk);
        q = dev ? rd_dev : rd_src;
        qerr = dev ? err_dev : err_src;
        psel_dev <= 1'b0;
        psel_src <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b1, 1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic clr;
        apb(1'b1, 1'b1, `OFF_STATUS, 32'h0);
        apb(1'b1, 1'b1, `OFF_ERRMAP, 32'h0);
    endtask
    function automatic logic [15:0] kv(input int i);
        return 16'h7a7a ^ 16'(i * 32'h0f13);
    endfunction
    task automatic t_reset;
        rdc(8'h20, 32'hffffffff, 32'h00007a7a);
        rdc(8'h24, 32'hffffffff, 32'h0);
        rdc(`OFF_MASK, 32'hffffffff, 32'h00003fff);
        apb(1'b1, 1'b0, 8'h40, 32'h0);
        chk({31'h0, qerr}, 32'h1);
        chk(q, 32'h0);
        // source side: key0 reset value and an unmapped word
        apb(1'b0, 1'b0, 8'h20, 32'h0);
        chk(q, 32'h00007a7a);
        apb(1'b0, 1'b0, 8'h08, 32'h0);
        chk({31'h0, qerr}, 32'h1);
        chk({31'h0, alarm_pin}, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_pattern;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 1'b1, 8'h20 + 8'(4 * i), 32'(kv(i)));
            apb(1'b1, 1'b1, 8'h20 + 8'(4 * i), 32'(kv(i)));
        end
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, 32'h10);
        cyc(6);
        chk({31'h0, aoe}, 32'h1);
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, 32'h211);
        apb(1'b0, 1'b1, 8'h00, 32'h1);
        chk({31'h0, aoe}, 32'h0);
        // settle for over 100 frames before discarding setup errors
        cyc(1700);
        apb(1'b0, 1'b0, `OFF_FRAMES, 32'h0);
        chk({31'h0, q[15:0] >= 16'h0064}, 32'h1);
        clr;
        cyc(200);
        rdc(`OFF_ERRMAP, 32'hffff, 32'h0);
        rdc(`OFF_STATUS, 32'h80, 32'h0);
        apb(1'b0, 1'b1, 8'h00, 32'h21);
        cyc(100);
        rdc(`OFF_ERRMAP, 32'hffff, 32'h1);
        rdc(`OFF_STATUS, 32'h80, 32'h80);
        apb(1'b1, 1'b1, `OFF_MASK, 32'h3f7f);
        cyc(4);
        chk({31'h0, alarm_pin}, 32'h1);
        apb(1'b0, 1'b1, 8'h00, 32'h1);
        cyc(50);
        clr;
        cyc(200);
        rdc(`OFF_ERRMAP, 32'hffff, 32'h0);
        chk({31'h0, alarm_pin}, 32'h0);
        // a changed key word on the cd lane shows as its bit only
        apb(1'b1, 1'b1, 8'h2c, 32'(kv(3) ^ 16'h0100));
        cyc(100);
        rdc(`OFF_ERRMAP, 32'hffff, 32'h100);
        apb(1'b1, 1'b1, 8'h2c, 32'(kv(3)));
        apb(1'b1, 1'b1, `OFF_MASK, 32'h3fff);
        $display("pattern test done");
    endtask
    task automatic par(input logic [31:0] s, input logic [31:0] d, input logic [31:0] e);
        apb(1'b0, 1'b1, 8'h00, s);
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, d);
        cyc(40);
        apb(1'b1, 1'b1, `OFF_STATUS, 32'h0);
        cyc(100);
        rdc(`OFF_STATUS, 32'hf00, e);
    endtask
    task automatic t_parity;
        par(32'h0b, 32'h1a, 32'h0);
        par(32'h0b, 32'h12, 32'h300);
        par(32'h0f, 32'h16, 32'hf00);
        par(32'h0f, 32'h1e, 32'h0);
        $display("parity test done");
    endtask
    task automatic t_alarms;
        apb(1'b0, 1'b1, 8'h00, 32'h1);
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, 32'h10);
        apb(1'b1, 1'b1, `OFF_SHUTOFF, 32'h3);
        cyc(40);
        clr;
        cyc(10);
        rdc(`OFF_STATUS, 32'h3fff, 32'h0);
        chk({31'h0, aoe}, 32'h1);
        rd_ptr <= 8'h01;
        cyc(10);
        rdc(`OFF_STATUS, 32'h1f, 32'h1e);
        chk({31'h0, aoe}, 32'h0);
        rd_ptr <= 8'h10;
        cyc(10);
        rdc(`OFF_STATUS, 32'h1f, 32'h1e);
        clr;
        wr_ptr <= 8'h00;
        cyc(10);
        rdc(`OFF_STATUS, 32'h1, 32'h1);
        wr_ptr <= 8'h01;
        sclk_run <= 1'b0;
        pll_locked <= 1'b0;
        apb(1'b0, 1'b1, 8'h00, 32'h0);
        cyc(60);
        rdc(`OFF_STATUS, 32'h3060, 32'h3060);
        chk({31'h0, aoe}, 32'h0);
        chk({31'h0, alarm_pin}, 32'h0);
        apb(1'b1, 1'b1, `OFF_MASK, 32'h1fff);
        cyc(4);
        chk({31'h0, alarm_pin}, 32'h1);
        $display("alarm test done");
    endtask
    // strobe marks frames, but not while it carries ab parity
    task automatic t_sync;
        apb(1'b0, 1'b1, 8'h00, 32'h21);
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, 32'h111);
        cyc(100);
        clr;
        cyc(100);
        rdc(`OFF_ERRMAP, 32'hffff, 32'h1);
        // leave test mode first so the earlier frame lock is dropped
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, 32'h10);
        apb(1'b1, 1'b1, `OFF_TEST_CTRL, 32'h117);
        cyc(100);
        clr;
        cyc(100);
        rdc(`OFF_ERRMAP, 32'hffff, 32'h0);
        $display("sync test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        errors++;
        print_verdict;
    end
    initial begin
        {presetn, psel_src, psel_dev, penable, pwrite, sample_clock} = 6'h0;
        {paddr, pwdata, errors, tests_run} = '0;
        wr_ptr = 8'h01;
        rd_ptr = 8'h10;
        {sclk_run, pll_locked, txen} = 3'h7;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_pattern;
        t_parity;
        t_sync;
        t_alarms;
        print_verdict;
    end
endmodule
`default_nettype wire
